// File: core/arxc_defs.vh
`ifndef ARXC_DEFS_VH
`define ARXC_DEFS_VH

// Register addresses
`define ARXC_A_MODE 3'h0
`define ARXC_A_CMD 3'h1
`define ARXC_A_STAT 3'h2
`define ARXC_A_DATA 3'h3
`define ARXC_A_CAUSE 3'h4
`define ARXC_A_MASK 3'h5

// Mode register fields
`define ARXC_M_LEN_LO 0
`define ARXC_M_LEN_HI 1
`define ARXC_M_PAR_EN 2
`define ARXC_M_PAR_ODD 3
`define ARXC_M_BLOCK 4
`define ARXC_M_CLK1X 5
`define ARXC_M_FLOW 6
`define ARXC_M_IRQ_FULL 7
`define ARXC_MODE_RST 8'h00

// Command register bits
`define ARXC_C_ENABLE 0
`define ARXC_C_DISABLE 1
`define ARXC_C_RXRESET 2
`define ARXC_C_ERRRESET 3

// Status register bits
`define ARXC_S_AVAIL 0
`define ARXC_S_FULL 1
`define ARXC_S_OVR 2
`define ARXC_S_PAR 3
`define ARXC_S_FRM 4
`define ARXC_S_BRK 5
`define ARXC_S_EN 6

// Cause bits (mask uses bit 0 for RX, bit 1 for COB) and mask reset
`define ARXC_I_COB 0
`define ARXC_I_RX 1
`define ARXC_I_IRQ 2
`define ARXC_MASK_RST 2'h0

// Timing counts in bit-clock ticks or crystal edges, queue depth, base length
`define ARXC_BIT_LAST_16X 4'hF
`define ARXC_HALF_LAST_16X 4'h7
`define ARXC_BIT_LAST_1X 4'h0
`define ARXC_HALF_LAST_1X 4'h0
`define ARXC_OVR_TICKS_16X 3'h6
`define ARXC_OVR_TICKS_1X 3'h1
`define ARXC_X1_EDGES 2'h2
`define ARXC_QDEPTH 2'h3
`define ARXC_LEN_BASE 4'h5

`endif

// File: core/arxc_sync.v
`timescale 1ns/1ps
module arxc_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!rst_n) begin
          s1[i] <= 1'b1;
          s2[i] <= 1'b1;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
        end
      end
    end
  endgenerate
  assign q = s2;
endmodule

// File: core/arxc_top.v
// Operation
// - After a falling edge, recheck line at 7.5 16x ticks or next 1x edge.
// - High at recheck discards start bit; low means valid start.
// - Sample each later bit once at its centre, LSB first.
// - Character complete after data, parity and half the stop bit.
// - Push character, flag availability, interrupt if enabled; upper unused bits zero.
// - Queue holds three characters, filled in arrival order.
// - Available flag while queue non-empty; full flag when three held; a mode bit picks one as interrupt source.
// - Data read returns oldest character then removes it with its flags.
// - Break, framing, parity stored per character before availability; overrun not stored.
// - Line low for whole character queues zero with break flag and change-of-break.
// - After break, hunt resumes only after two crystal edges with line high.
// - Framing error when a non-break character (non-zero data or parity bit high) has stop bit sampled low.
// - Line still low half a bit after stop sample acts as start.
// - Parity error when computed parity differs from received parity bit.
// - Character mode shows head character flags; they clear when it is read.
// - Full queue plus held character plus new start sets overrun unless read.
// - Overrun clears only on error reset or receiver reset; queuing resumes when a slot frees.
// - Change-of-break set at break start and end, cleared by error reset.
// - A disabled receiver never raises an interrupt.
// - Block mode flags OR all characters reaching head since error reset.
// - Status read leaves queue alone; only data read pops.
// - Flow control negates request-to-send on valid start with full queue.
// - Receiver reset clears pointers, status, pins and interrupt; needs re-enable.
`timescale 1ns/1ps
`include "arxc_defs.vh"
module arxc_top (
  input wire SYS_CLK,
  input wire RST_N,
  input wire RXD,
  input wire BIT_CLK,
  input wire CRYSTAL_CLOCK_IN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  output reg CHAR_AVAILABLE_FLAG,
  output reg QUEUE_FULL_FLAG,
  output reg REQUEST_TO_SEND_N_OUT,
  output reg INTERRUPT_REQUEST_N
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_BRK = 4'b1000;

  wire [2:0] sync_q;
  wire rx;
  wire bclk;
  wire xclk;
  reg rx_d;
  reg bclk_d;
  reg xclk_d;
  wire tick;
  wire xedge;

  reg [7:0] mode_reg_one;
  reg [1:0] mask_reg;
  reg en;
  reg [3:0] state;
  reg [3:0] tcnt;
  reg [3:0] bitn;
  reg [7:0] sh;
  reg par_rx;
  reg [1:0] xcnt;
  reg done;
  reg [10:0] done_word;
  reg vstart;
  reg cob_ev;

  reg [10:0] receive_queue [0:2];
  reg [1:0] rd_ptr;
  reg [1:0] q_cnt;
  reg [10:0] hold;
  reg hold_v;
  reg ovr_arm;
  reg [2:0] ovr_cnt;
  reg overrun;
  reg rts_neg;
  reg [2:0] blk_flags;
  reg change_of_break;

  wire wr_mode;
  wire wr_cmd;
  wire wr_mask;
  wire cmd_en;
  wire cmd_dis;
  wire cmd_rst;
  wire cmd_err;
  wire pop;
  wire clk1x;
  wire par_en;
  wire [3:0] nbits;
  wire [3:0] last_idx;
  wire [3:0] bit_last;
  wire [3:0] half_last;
  wire [2:0] ovr_lim;
  wire full;
  wire avail;
  wire slot;
  wire [1:0] wr_pos;
  wire [2:0] wr_sum;
  wire [10:0] head;
  wire [2:0] shown;
  wire rx_cond;
  wire irq;
  wire brk_now;
  wire [7:0] channel_status_reg;
  wire [7:0] interrupt_cause_reg;

  arxc_sync #(
    .W(3)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d({CRYSTAL_CLOCK_IN, BIT_CLK, RXD}),
    .q(sync_q)
  );
  // Synchronised line and clocks
  assign rx = sync_q[0];
  assign bclk = sync_q[1];
  assign xclk = sync_q[2];

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_d <= 1'b1;
      bclk_d <= 1'b1;
      xclk_d <= 1'b1;
    end else begin
      rx_d <= rx;
      bclk_d <= bclk;
      xclk_d <= xclk;
    end
  end
  assign tick = bclk & ~bclk_d;
  assign xedge = xclk ^ xclk_d;

  // Register bus decode
  assign wr_mode = WR & (ADDR == `ARXC_A_MODE);
  assign wr_cmd = WR & (ADDR == `ARXC_A_CMD);
  assign wr_mask = WR & (ADDR == `ARXC_A_MASK);
  assign cmd_en = wr_cmd & WDATA[`ARXC_C_ENABLE];
  assign cmd_dis = wr_cmd & WDATA[`ARXC_C_DISABLE];
  assign cmd_rst = wr_cmd & WDATA[`ARXC_C_RXRESET];
  assign cmd_err = wr_cmd & WDATA[`ARXC_C_ERRRESET];
  assign pop = RD & (ADDR == `ARXC_A_DATA) & (q_cnt != 2'h0);

  assign clk1x = mode_reg_one[`ARXC_M_CLK1X];
  assign par_en = mode_reg_one[`ARXC_M_PAR_EN];
  assign nbits = `ARXC_LEN_BASE + {2'h0, mode_reg_one[`ARXC_M_LEN_HI:`ARXC_M_LEN_LO]};
  assign last_idx = nbits + {3'h0, par_en};
  assign bit_last = clk1x ? `ARXC_BIT_LAST_1X : `ARXC_BIT_LAST_16X;
  assign half_last = clk1x ? `ARXC_HALF_LAST_1X : `ARXC_HALF_LAST_16X;
  assign ovr_lim = clk1x ? `ARXC_OVR_TICKS_1X : `ARXC_OVR_TICKS_16X;
  assign brk_now = (sh == 8'h00) & ~(par_en & par_rx) & ~rx;

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mode_reg_one <= `ARXC_MODE_RST;
      mask_reg <= `ARXC_MASK_RST;
    end else begin
      if (wr_mode) begin
        mode_reg_one <= WDATA;
      end
      if (wr_mask) begin
        mask_reg <= WDATA[1:0];
      end
    end
  end

  // Receive state machine
  always @(posedge SYS_CLK) begin
    if (!RST_N || cmd_rst) begin
      en <= 1'b0;
      state <= ST_IDLE;
      tcnt <= 4'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      par_rx <= 1'b0;
      xcnt <= 2'h0;
      done <= 1'b0;
      done_word <= 11'h000;
      vstart <= 1'b0;
      cob_ev <= 1'b0;
    end else begin
      done <= 1'b0;
      vstart <= 1'b0;
      cob_ev <= 1'b0;
      if (cmd_en) begin
        en <= 1'b1;
      end
      if (cmd_dis) begin
        en <= 1'b0;
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (en & ~rx & rx_d) begin
              state <= ST_START;
              tcnt <= 4'h0;
            end
          end
          ST_START: begin
            if (tick) begin
              tcnt <= tcnt + 4'h1;
              if (tcnt == half_last) begin
                if (rx) begin
                  state <= ST_IDLE;
                end else begin
                  state <= ST_DATA;
                  vstart <= 1'b1;
                  tcnt <= 4'h0;
                  bitn <= 4'h0;
                  sh <= 8'h00;
                  par_rx <= 1'b0;
                end
              end
            end
          end
          ST_DATA: begin
            if (tick) begin
              tcnt <= tcnt + 4'h1;
              if (tcnt == bit_last) begin
                tcnt <= 4'h0;
                bitn <= bitn + 4'h1;
                if (bitn < nbits) begin
                  sh[bitn[2:0]] <= rx;
                end else if (bitn < last_idx) begin
                  par_rx <= rx;
                end else begin
                  // Stop bit centre: character complete
                  done <= 1'b1;
                  if (brk_now) begin
                    done_word <= {3'b100, 8'h00};
                    cob_ev <= 1'b1;
                    xcnt <= 2'h0;
                    state <= ST_BRK;
                  end else begin
                    done_word[10] <= 1'b0;
                    done_word[9] <= ~rx;
                    done_word[8] <= par_en & (^sh ^ par_rx ^ mode_reg_one[`ARXC_M_PAR_ODD]);
                    done_word[7:0] <= sh;
                    // Low stop bit: recheck half a bit later as a start
                    state <= rx ? ST_IDLE : ST_START;
                    tcnt <= 4'h0;
                  end
                end
              end
            end
          end
          ST_BRK: begin
            if (~rx) begin
              xcnt <= 2'h0;
            end else if (xcnt == `ARXC_X1_EDGES) begin
              state <= ST_IDLE;
              cob_ev <= 1'b1;
            end else if (xedge) begin
              xcnt <= xcnt + 2'h1;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Receive queue
  function [1:0] wr_pos_wrap;
    input [2:0] s;
    reg [2:0] t;
    begin
      t = s - 3'h3;
      wr_pos_wrap = t[1:0];
    end
  endfunction
  assign full = (q_cnt == `ARXC_QDEPTH);
  assign avail = (q_cnt != 2'h0);
  assign slot = ~full | pop;
  // Sum kept three bits wide so a pointer plus count past three cannot wrap
  assign wr_sum = {1'b0, rd_ptr} + {1'b0, q_cnt};
  assign wr_pos = (wr_sum >= 3'h3) ? wr_pos_wrap(wr_sum) : wr_sum[1:0];
  assign head = receive_queue[rd_ptr];

  always @(posedge SYS_CLK) begin
    if (!RST_N || cmd_rst) begin
      rd_ptr <= 2'h0;
      q_cnt <= 2'h0;
      hold <= 11'h000;
      hold_v <= 1'b0;
    end else begin
      if (hold_v & slot) begin
        receive_queue[wr_pos] <= hold;
        hold_v <= done;
        hold <= done_word;
        q_cnt <= pop ? q_cnt : q_cnt + 2'h1;
      end else if (done & slot) begin
        receive_queue[wr_pos] <= done_word;
        q_cnt <= pop ? q_cnt : q_cnt + 2'h1;
      end else begin
        if (done) begin
          hold <= done_word;
          hold_v <= 1'b1;
        end
        if (pop) begin
          q_cnt <= q_cnt - 2'h1;
        end
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == 2'h2) ? 2'h0 : rd_ptr + 2'h1;
      end
    end
  end

  // Overrun, flow control, break change and block flags
  always @(posedge SYS_CLK) begin
    if (!RST_N || cmd_rst) begin
      ovr_arm <= 1'b0;
      ovr_cnt <= 3'h0;
      overrun <= 1'b0;
      rts_neg <= 1'b0;
      blk_flags <= 3'h0;
      change_of_break <= 1'b0;
    end else begin
      if (vstart & full & hold_v & ~pop) begin
        ovr_arm <= 1'b1;
        ovr_cnt <= 3'h0;
      end else if (pop) begin
        ovr_arm <= 1'b0;
      end else if (ovr_arm & tick) begin
        ovr_cnt <= ovr_cnt + 3'h1;
        if (ovr_cnt + 3'h1 == ovr_lim) begin
          ovr_arm <= 1'b0;
        end
      end
      if (ovr_arm & tick & ~pop & (ovr_cnt + 3'h1 == ovr_lim)) begin
        overrun <= 1'b1;
      end else if (cmd_err) begin
        overrun <= 1'b0;
      end
      if (vstart & full & mode_reg_one[`ARXC_M_FLOW]) begin
        rts_neg <= 1'b1;
      end else if (~full | ~mode_reg_one[`ARXC_M_FLOW]) begin
        rts_neg <= 1'b0;
      end
      if (cob_ev) begin
        change_of_break <= 1'b1;
      end else if (cmd_err) begin
        change_of_break <= 1'b0;
      end
      if (avail) begin
        blk_flags <= (cmd_err ? 3'h0 : blk_flags) | head[10:8];
      end else if (cmd_err) begin
        blk_flags <= 3'h0;
      end
    end
  end

  // Character mode shows the head only
  assign shown = mode_reg_one[`ARXC_M_BLOCK] ? blk_flags : (avail ? head[10:8] : 3'h0);
  assign channel_status_reg = {1'b0, en, shown, overrun, full, avail};
  assign rx_cond = mode_reg_one[`ARXC_M_IRQ_FULL] ? full : avail;
  assign irq = en & ((rx_cond & mask_reg[0]) | (change_of_break & mask_reg[1]));
  assign interrupt_cause_reg = {5'h00, irq, rx_cond, change_of_break};

  // Read port and pins
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      CHAR_AVAILABLE_FLAG <= 1'b0;
      QUEUE_FULL_FLAG <= 1'b0;
      REQUEST_TO_SEND_N_OUT <= 1'b0;
      INTERRUPT_REQUEST_N <= 1'b1;
    end else begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `ARXC_A_MODE: RDATA <= mode_reg_one;
          `ARXC_A_STAT: RDATA <= channel_status_reg;
          `ARXC_A_DATA: RDATA <= avail ? head[7:0] : 8'h00;
          `ARXC_A_CAUSE: RDATA <= interrupt_cause_reg;
          `ARXC_A_MASK: RDATA <= {6'h00, mask_reg};
          default: RDATA <= 8'h00;
        endcase
      end
      CHAR_AVAILABLE_FLAG <= avail;
      QUEUE_FULL_FLAG <= full;
      REQUEST_TO_SEND_N_OUT <= rts_neg;
      INTERRUPT_REQUEST_N <= ~irq;
    end
  end
endmodule

// File: tb/arxc_props.sv
`timescale 1ns/1ps
`include "arxc_defs.vh"
module arxc_props (
  input wire SYS_CLK,
  input wire RST_N,
  input wire RXD,
  input wire BIT_CLK,
  input wire CRYSTAL_CLOCK_IN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire CHAR_AVAILABLE_FLAG,
  input wire QUEUE_FULL_FLAG,
  input wire REQUEST_TO_SEND_N_OUT,
  input wire INTERRUPT_REQUEST_N
);
  wire pop = RD && ADDR == `ARXC_A_DATA;
  wire st_rd = RD && ADDR == `ARXC_A_STAT;
  wire cmd = WR && ADDR == `ARXC_A_CMD;
  wire rx_rst = cmd && WDATA[`ARXC_C_RXRESET];
  reg en;
  reg [2:0] clr_h;
  always @(posedge SYS_CLK) begin
    if (!RST_N || (cmd && (WDATA[`ARXC_C_DISABLE] || WDATA[`ARXC_C_RXRESET]))) begin
      en <= 1'b0;
    end else if (cmd && WDATA[`ARXC_C_ENABLE]) begin
      en <= 1'b1;
    end
  end
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      clr_h <= 3'h0;
    end else begin
      clr_h <= {clr_h[1:0], pop || rx_rst};
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence st_hold;
    st_rd && CHAR_AVAILABLE_FLAG ##1 !(pop || rx_rst);
  endsequence
  AST_FULL_AVAIL: assert property (QUEUE_FULL_FLAG |-> CHAR_AVAILABLE_FLAG)
    else $error("full without available");
  AST_AVAIL_FALL: assert property ($fell(CHAR_AVAILABLE_FLAG) |-> clr_h != 3'h0)
    else $error("available fell without data read");
  AST_FULL_FALL: assert property ($fell(QUEUE_FULL_FLAG) |-> clr_h != 3'h0)
    else $error("full fell without data read");
  AST_STAT_KEEP: assert property (st_hold |=> ##1 CHAR_AVAILABLE_FLAG)
    else $error("status read removed a character");
  AST_RTS_NEG: assert property ($rose(REQUEST_TO_SEND_N_OUT) |-> QUEUE_FULL_FLAG)
    else $error("request to send negated with room");
  AST_RTS_BACK: assert property ($fell(QUEUE_FULL_FLAG) |-> ##[0:3] !REQUEST_TO_SEND_N_OUT)
    else $error("request to send not reasserted");
  AST_IRQ_OFF: assert property (!en && !$past(en) && !$past(en, 2) |-> INTERRUPT_REQUEST_N)
    else $error("disabled receiver interrupts");
  AST_RXRST: assert property (rx_rst |-> ##3 (!CHAR_AVAILABLE_FLAG && !QUEUE_FULL_FLAG
    && !REQUEST_TO_SEND_N_OUT && INTERRUPT_REQUEST_N))
    else $error("receiver reset left status");
endmodule
bind arxc_top arxc_props props_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RXD(RXD),
  .BIT_CLK(BIT_CLK), .CRYSTAL_CLOCK_IN(CRYSTAL_CLOCK_IN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CHAR_AVAILABLE_FLAG(CHAR_AVAILABLE_FLAG),
  .QUEUE_FULL_FLAG(QUEUE_FULL_FLAG), .REQUEST_TO_SEND_N_OUT(REQUEST_TO_SEND_N_OUT),
  .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N));

// File: tb/arxc_rtx.sv
`timescale 1ns/1ps
module arxc_rtx (
  input wire BIT_CLK,
  output reg RXD
);
  initial RXD = 1'b1;
  task tick(input integer n);
    repeat (n) @(posedge BIT_CLK);
  endtask
  task bitout(input b);
    begin
      RXD = b;
      tick(16);
    end
  endtask
  // Start, data LSB first, parity, stop, then idle high
  task send(input [7:0] d, input integer n, input p_en, input p, input stop);
    integer i;
    begin
      bitout(1'b0);
      for (i = 0; i < n; i = i + 1) begin
        bitout(d[i]);
      end
      if (p_en) begin
        bitout(p);
      end
      bitout(stop);
      bitout(1'b1);
    end
  endtask
endmodule

// File: tb/arxc_top_tb.sv
`timescale 1ns/1ps
`include "arxc_defs.vh"
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module arxc_top_tb;
  reg SYS_CLK = 0;
  reg RST_N = 0;
  reg BIT_CLK = 0;
  reg CRYSTAL_CLOCK_IN = 0;
  reg WR = 0;
  reg RD = 0;
  reg [2:0] ADDR = 3'h0;
  reg [7:0] WDATA = 8'h00;
  reg [7:0] rv;
  wire RXD;
  wire [7:0] RDATA;
  wire avail;
  wire full;
  wire rts_n;
  wire irq_n;
  integer mismatches = 0;
  integer checked = 0;
  integer cyc = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  always #24 BIT_CLK = ~BIT_CLK;
  always #37 CRYSTAL_CLOCK_IN = ~CRYSTAL_CLOCK_IN;
  arxc_top dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RXD(RXD), .BIT_CLK(BIT_CLK),
    .CRYSTAL_CLOCK_IN(CRYSTAL_CLOCK_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CHAR_AVAILABLE_FLAG(avail), .QUEUE_FULL_FLAG(full),
    .REQUEST_TO_SEND_N_OUT(rts_n), .INTERRUPT_REQUEST_N(irq_n));
  arxc_rtx rtx_u (.BIT_CLK(BIT_CLK), .RXD(RXD));
  task print_verdict;
    begin
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  // Flag pins follow a pop or command two edges later
  task wait_pins;
    begin
      repeat (2) @(posedge SYS_CLK);
      #1;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
      @(posedge SYS_CLK);
    end
  endtask
  task rd(input [2:0] a);
    begin
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 rv = RDATA;
      @(posedge SYS_CLK);
    end
  endtask
  task tx(input [7:0] d, input integer n, input p_en, input p, input stop);
    begin
      rtx_u.send(d, n, p_en, p, stop);
      repeat (4) @(posedge SYS_CLK);
    end
  endtask
  task t_char;
    begin
      wr(`ARXC_A_MODE, 8'h07);
      rd(`ARXC_A_MODE);
      `CHK(rv, 8'h07)
      wr(`ARXC_A_CMD, 8'h01);
      tx(8'hA5, 8, 1'b1, ^8'hA5, 1'b1);
      `CHK(avail, 1'b1)
      tx(8'h3C, 8, 1'b1, ~^8'h3C, 1'b1);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_PAR], 1'b0)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'hA5)
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_PAR], 1'b1)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h3C)
      wait_pins;
      `CHK(avail, 1'b0)
    end
  endtask
  task t_short;
    begin
      wr(`ARXC_A_MODE, 8'h00);
      wr(`ARXC_A_MASK, 8'h01);
      tx(8'hFF, 5, 1'b0, 1'b0, 1'b1);
      `CHK(irq_n, 1'b0)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h1F)
      wait_pins;
      `CHK(irq_n, 1'b1)
    end
  endtask
  task t_full;
    begin
      wr(`ARXC_A_MODE, 8'h43);
      tx(8'h11, 8, 1'b0, 1'b0, 1'b1);
      tx(8'h22, 8, 1'b0, 1'b0, 1'b1);
      tx(8'h33, 8, 1'b0, 1'b0, 1'b1);
      `CHK(full, 1'b1)
      `CHK(rts_n, 1'b0)
      tx(8'h44, 8, 1'b0, 1'b0, 1'b1);
      `CHK(rts_n, 1'b1)
      tx(8'h55, 8, 1'b0, 1'b0, 1'b1);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_OVR], 1'b1)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h11)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h22)
      wait_pins;
      `CHK(rts_n, 1'b0)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h33)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h55)
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_OVR], 1'b1)
      wr(`ARXC_A_CMD, 8'h08);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_OVR], 1'b0)
    end
  endtask
  task t_brk;
    begin
      tx(8'h00, 8, 1'b0, 1'b0, 1'b0);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_BRK], 1'b1)
      rd(`ARXC_A_CAUSE);
      `CHK(rv[`ARXC_I_COB], 1'b1)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h00)
      wr(`ARXC_A_CMD, 8'h08);
      rd(`ARXC_A_CAUSE);
      `CHK(rv[`ARXC_I_COB], 1'b0)
      tx(8'h81, 8, 1'b0, 1'b0, 1'b0);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_FRM], 1'b1)
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h81)
    end
  endtask
  // Block mode, odd parity: error sticks past the read until error reset
  task t_block;
    begin
      wr(`ARXC_A_MODE, 8'h1F);
      tx(8'h12, 8, 1'b1, ^8'h12, 1'b1);
      rd(`ARXC_A_DATA);
      `CHK(rv, 8'h12)
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_PAR], 1'b1)
      wr(`ARXC_A_CMD, 8'h08);
      rd(`ARXC_A_STAT);
      `CHK(rv[`ARXC_S_PAR], 1'b0)
      wr(`ARXC_A_MODE, 8'h43);
    end
  endtask
  task t_rst;
    begin
      tx(8'h5A, 8, 1'b0, 1'b0, 1'b1);
      wr(`ARXC_A_CMD, 8'h04);
      wait_pins;
      `CHK(avail, 1'b0)
      rd(`ARXC_A_STAT);
      `CHK(rv, 8'h00)
      tx(8'h6B, 8, 1'b0, 1'b0, 1'b1);
      `CHK(avail, 1'b0)
    end
  endtask
  initial begin
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    t_char;
    t_short;
    t_full;
    t_brk;
    t_block;
    t_rst;
    print_verdict;
  end
endmodule
